// ===== rtl/atf_ctrl.sv
// Converter trigger selection, conversion sequencing, result FIFO and pre-trigger stop.
// Assumes one 100 MHz clock; converter result arrives on a same-clock handshake.
//
// Functional notes
// (RULE_01) Source select 0: software write triggers
// (RULE_02) Source select 1: cascaded pacer triggers
// (RULE_03) External enable: falling edge triggers, pacer ignored
// (RULE_04) Results buffered in 1024-word FIFO
// (RULE_05) Full FIFO drops further results
// (RULE_06) Store on completion; not-empty flag
// (RULE_07) Idle flag low while converting
// (RULE_08) Conversion finishes within 10us or 4us
// (RULE_09) Half-full flag at 512 words
// (RULE_10) Full flag reports buffer overflow
// (RULE_11) EOC interrupt when result readable
// (RULE_12) Half-full interrupt at 512 words
// (RULE_13) Pre-trigger mode keeps acquiring while waiting
// (RULE_14) After pretrigger, count down, stop at zero
// (RULE_15) Stop count accepts 1 to 65535
// (RULE_16) Count 1 gives one extra sample
// (RULE_17) Host arms in fixed order
// (RULE_18) Host drains and polls stop count
// (RULE_19) Results are 16-bit two's complement
// (RULE_20) Interrupt source select: EOC or half-full
// (RULE_21) FIFO disable bit high clears FIFO
// (RULE_22) Any trigger write gives one pulse
// (RULE_23) Pins synchronised, one event per edge
// (RULE_24) Triggers during conversion ignored
`timescale 1ns/1ps
module atf_ctrl
  import atf_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic TRIGGER_SOURCE_SELECT,
  input wire logic EXTERNAL_TRIGGER_ENABLE,
  input wire logic IRQ_SOURCE_SELECT,
  input wire logic FIFO_DISABLE_BIT,
  input wire logic FAST_VARIANT,
  input wire logic SW_TRIGGER_WR,
  input wire logic [PACER_W-1:0] PACER_DIV1,
  input wire logic [PACER_W-1:0] PACER_DIV2,
  input wire logic EXTERNAL_TRIGGER_INPUT,
  input wire logic PRETRIGGER_MODE,
  input wire logic PRETRIGGER_INPUT,
  input wire logic STOP_COUNT_LOAD,
  input wire logic [STOP_W-1:0] STOP_COUNT_VALUE,
  output logic [STOP_W-1:0] STOP_COUNT,
  output logic CONV_START,
  input wire logic CONV_DONE,
  input wire logic [DATA_W-1:0] CONV_DATA,
  input wire logic FIFO_READ,
  output logic [DATA_W-1:0] FIFO_DATA,
  output logic FIFO_NOT_EMPTY_FLAG,
  output logic FIFO_HALF_FLAG,
  output logic FIFO_FULL_FLAG,
  output logic CONVERTER_IDLE_FLAG,
  output logic IRQ1
);
  atf_conv_e state_r;
  atf_conv_e state_nxt;
  logic [2:0] ext_sync_r;
  logic [2:0] ptg_sync_r;
  logic ext_lvl_r;
  logic ptg_lvl_r;
  logic [PACER_W-1:0] pc1_r;
  logic [PACER_W-1:0] pc2_r;
  logic [CONV_CNT_W-1:0] conv_cnt_r;
  logic [STOP_W-1:0] stop_r;
  logic armed_r;
  logic stopped_r;
  logic [DATA_W-1:0] res_r;
  logic res_v_r;
  logic [CNT_W-1:0] level;
  logic [DATA_W-1:0] head;
  logic sk_in_ready;
  logic sk_out_valid;
  logic [DATA_W-1:0] sk_out_data;
  logic eoc_r;

  // Returns cycle limit for the selected variant
  function automatic logic [CONV_CNT_W-1:0] conv_limit(input logic fast);
    conv_limit = fast ? CONV_CNT_W'(CONV_FAST_CYC - 1) : CONV_CNT_W'(CONV_STD_CYC - 1);
  endfunction

  // Stable level once second and third stages agree
  function automatic logic settled(input logic [2:0] s, input logic prev);
    settled = (s[1] == s[2]) ? s[1] : prev;
  endfunction

  // Input synchronisers and debounced levels
  wire ext_lvl_nxt = settled(ext_sync_r, ext_lvl_r);
  wire ptg_lvl_nxt = settled(ptg_sync_r, ptg_lvl_r);
  wire ext_fall = ext_lvl_r && !ext_lvl_nxt; // RULE_23
  wire ptg_rise = !ptg_lvl_r && ptg_lvl_nxt; // RULE_23

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      ext_sync_r <= SYNC_RESET;
      ptg_sync_r <= 3'b000;
      ext_lvl_r <= 1'b1;
      ptg_lvl_r <= 1'b0;
    end
    else if (CE)
    begin
      ext_sync_r <= {ext_sync_r[1:0], EXTERNAL_TRIGGER_INPUT};
      ptg_sync_r <= {ptg_sync_r[1:0], PRETRIGGER_INPUT};
      ext_lvl_r <= ext_lvl_nxt;
      ptg_lvl_r <= ptg_lvl_nxt;
    end
  end

  // Two cascaded pacer counters; stage two counts stage one wraps
  wire pc1_wrap = (pc1_r == '0);
  wire pc2_wrap = (pc2_r == '0);
  wire pacer_pulse = pc1_wrap && pc2_wrap; // RULE_02

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      pc1_r <= PACER_RESET;
      pc2_r <= PACER_RESET;
    end
    else if (CE)
    begin
      pc1_r <= pc1_wrap ? PACER_DIV1 : pc1_r - 1'b1;
      if (pc1_wrap)
        pc2_r <= pc2_wrap ? PACER_DIV2 : pc2_r - 1'b1;
    end
  end

  // Trigger selection; external enable overrides the pacer/software choice
  wire sw_trig = !TRIGGER_SOURCE_SELECT && SW_TRIGGER_WR; // RULE_01 RULE_22
  wire int_trig = TRIGGER_SOURCE_SELECT ? pacer_pulse : sw_trig; // RULE_02
  wire raw_trig = EXTERNAL_TRIGGER_ENABLE ? ext_fall : int_trig; // RULE_03
  wire trig_allowed = !stopped_r; // RULE_13 RULE_14
  wire trig_take = raw_trig && trig_allowed && (state_r == ATF_IDLE); // RULE_24

  // Pre-trigger stop counter: arms on pretrigger edge, counts triggers
  wire ptg_hit = PRETRIGGER_MODE && ptg_rise && !armed_r;
  wire cnt_trig = trig_take && armed_r && (stop_r != '0);

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      stop_r <= STOP_RESET;
      armed_r <= 1'b0;
      stopped_r <= 1'b0;
    end
    else if (CE)
    begin
      if (!PRETRIGGER_MODE)
      begin
        armed_r <= 1'b0; // RULE_17
        stopped_r <= 1'b0;
        if (STOP_COUNT_LOAD)
          stop_r <= STOP_COUNT_VALUE; // RULE_15
      end
      else
      begin
        if (ptg_hit)
          armed_r <= 1'b1; // RULE_14
        if (cnt_trig)
          stop_r <= stop_r - 1'b1; // RULE_14
        if (cnt_trig && stop_r == 16'h0001)
          stopped_r <= 1'b1; // RULE_16
      end
    end
  end

  // Conversion sequencer
  wire conv_timeout = (conv_cnt_r == conv_limit(FAST_VARIANT)); // RULE_08

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ATF_IDLE: if (trig_take) state_nxt = ATF_CONV;
      ATF_CONV: if (CONV_DONE || conv_timeout) state_nxt = ATF_STORE;
      ATF_STORE: state_nxt = ATF_IDLE;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      state_r <= ATF_IDLE;
      conv_cnt_r <= CONV_CNT_RESET;
      res_r <= DATA_RESET;
      res_v_r <= 1'b0;
      CONV_START <= 1'b0;
      CONVERTER_IDLE_FLAG <= 1'b1;
    end
    else if (CE)
    begin
      state_r <= state_nxt;
      CONV_START <= trig_take;
      CONVERTER_IDLE_FLAG <= (state_nxt == ATF_IDLE); // RULE_07
      conv_cnt_r <= (state_r == ATF_CONV) ? conv_cnt_r + 1'b1 : CONV_CNT_RESET;
      if (state_r == ATF_CONV && state_nxt == ATF_STORE)
      begin
        res_r <= CONV_DATA; // RULE_19
        res_v_r <= 1'b1; // RULE_06
      end
      else if (sk_in_ready)
        res_v_r <= 1'b0;
    end
  end

  // Two-entry buffer between the result register and the FIFO write; its output is always ready
  wire fifo_space = (level != FULL_LEVEL);
  wire fifo_push = sk_out_valid && !FIFO_DISABLE_BIT;

  atf_skid u_skid (
    .clk(MCLK),
    .rst_n(RST_N),
    .ce(CE),
    .in_valid(res_v_r),
    .in_ready(sk_in_ready),
    .in_data(res_r),
    .out_valid(sk_out_valid),
    .out_ready(1'b1),
    .out_data(sk_out_data)
  );

  // Result FIFO; a full FIFO drops the word, disable holds it cleared
  atf_fifo u_fifo (
    .clk(MCLK),
    .rst_n(RST_N),
    .ce(CE),
    .clr(FIFO_DISABLE_BIT), // RULE_21
    .push(fifo_push && fifo_space), // RULE_04 RULE_05
    .push_data(sk_out_data),
    .pop(FIFO_READ),
    .head(head),
    .level(level)
  );

  // Registered flags, data and interrupt
  wire eoc_evt = fifo_push && fifo_space; // RULE_11
  wire half_now = (level >= HALF_LEVEL); // RULE_09

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      FIFO_NOT_EMPTY_FLAG <= 1'b0;
      FIFO_HALF_FLAG <= 1'b0;
      FIFO_FULL_FLAG <= 1'b0;
      FIFO_DATA <= DATA_RESET;
      STOP_COUNT <= STOP_RESET;
      eoc_r <= 1'b0;
      IRQ1 <= 1'b0;
    end
    else if (CE)
    begin
      FIFO_NOT_EMPTY_FLAG <= (level != '0); // RULE_06
      FIFO_HALF_FLAG <= half_now; // RULE_09
      FIFO_FULL_FLAG <= (level == FULL_LEVEL); // RULE_10
      FIFO_DATA <= head;
      STOP_COUNT <= stop_r; // RULE_18
      eoc_r <= eoc_evt;
      IRQ1 <= IRQ_SOURCE_SELECT ? half_now : eoc_r; // RULE_12 RULE_20
    end
  end
endmodule

// ===== inc/atf_pkg.sv
// Shared constants and types for the converter trigger, FIFO and pre-trigger block.
// Assumes a single 100 MHz clock domain.
package atf_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FIFO_DEPTH = 1024;
  localparam int unsigned FIFO_AW = 10;
  localparam int unsigned CNT_W = 11;
  localparam logic [CNT_W-1:0] HALF_LEVEL = 11'h0200;
  localparam logic [CNT_W-1:0] FULL_LEVEL = 11'h0400;
  localparam int unsigned STOP_W = 16;
  localparam logic [STOP_W-1:0] STOP_RESET = 16'h0000;
  // Conversion time bounds in ns and derived cycle counts (longest time rounds down)
  localparam int unsigned CONV_STD_NS = 10000;
  localparam int unsigned CONV_FAST_NS = 4000;
  localparam int unsigned CONV_STD_CYC = CONV_STD_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_FAST_CYC = CONV_FAST_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_CNT_W = 10;
  localparam logic [CONV_CNT_W-1:0] CONV_CNT_RESET = 10'h000;
  // Pacer prescaler width per cascaded stage
  localparam int unsigned PACER_W = 16;
  localparam logic [PACER_W-1:0] PACER_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [2:0] SYNC_RESET = 3'b111;
  typedef enum logic [1:0] {ATF_IDLE, ATF_CONV, ATF_STORE} atf_conv_e;
endpackage

// ===== rtl/atf_skid.sv
// Two-entry valid/ready buffer in the result path.
// Assumes one clock, synchronous active-low reset and a clock enable.
`timescale 1ns/1ps
module atf_skid
  import atf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [DATA_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [DATA_W-1:0] out_data
);
  logic [DATA_W-1:0] mem_r [2];
  logic [1:0] cnt_r;
  logic rd_r;
  logic wr_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Status from occupancy
  assign in_ready = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data = mem_r[rd_r];

  // Pointer and count update
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= 2'd0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end
    else if (ce)
    begin
      if (push)
      begin
        mem_r[wr_r] <= in_data;
        wr_r <= ~wr_r;
      end
      if (pop)
        rd_r <= ~rd_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ===== rtl/atf_fifo.sv
// 1024-word result FIFO with occupancy count.
// Assumes one clock; clear is synchronous and dominates push and pop.
`timescale 1ns/1ps
module atf_fifo
  import atf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic push,
  input wire logic [DATA_W-1:0] push_data,
  input wire logic pop,
  output logic [DATA_W-1:0] head,
  output logic [CNT_W-1:0] level
);
  logic [DATA_W-1:0] mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wp_r;
  logic [FIFO_AW-1:0] rp_r;
  logic [CNT_W-1:0] cnt_r;
  wire do_push = push && (cnt_r != FULL_LEVEL);
  wire do_pop = pop && (cnt_r != '0);

  assign head = mem[rp_r];
  assign level = cnt_r;

  // Storage and pointers
  always_ff @(posedge clk)
  begin
    if (!rst_n || (ce && clr))
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else if (ce)
    begin
      if (do_push)
      begin
        mem[wp_r] <= push_data;
        wp_r <= wp_r + 1'b1;
      end
      if (do_pop)
        rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, do_push} - {{(CNT_W-1){1'b0}}, do_pop};
    end
  end
endmodule

// ===== tb/atf_ctrl_checker.sv
// Port checks for atf_ctrl.
// Assumes CE is held high.
`timescale 1ns/1ps
module atf_ctrl_checker
  import atf_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic IRQ_SOURCE_SELECT,
  input wire logic FIFO_DISABLE_BIT,
  input wire logic PRETRIGGER_MODE,
  input wire logic [STOP_W-1:0] STOP_COUNT,
  input wire logic CONV_START,
  input wire logic FIFO_NOT_EMPTY_FLAG,
  input wire logic FIFO_HALF_FLAG,
  input wire logic FIFO_FULL_FLAG,
  input wire logic CONVERTER_IDLE_FLAG,
  input wire logic IRQ1
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Busy cycles of the current conversion, for the conversion time bound
  localparam logic [10:0] BUSY_MAX = 11'h3EA;
  logic [10:0] busy_cnt_r;
  always_ff @(posedge MCLK)
  begin
    if (!RST_N || CONVERTER_IDLE_FLAG)
      busy_cnt_r <= 11'h000;
    else
      busy_cnt_r <= busy_cnt_r + 11'h001;
  end
  // Start pulse and idle flag
  a_start_pulse: assert property (CONV_START |=> !CONV_START)
    else $error("start too long");
  a_idle_low: assert property (CONV_START |-> !CONVERTER_IDLE_FLAG)
    else $error("idle during start");
  a_no_retrig: assert property (CONV_START |-> $past(CONVERTER_IDLE_FLAG))
    else $error("start while busy");
  a_conv_bound: assert property (busy_cnt_r <= BUSY_MAX)
    else $error("conversion too long");
  // FIFO flags, interrupt and pre-trigger stop hold
  a_full_half: assert property (FIFO_FULL_FLAG |-> FIFO_HALF_FLAG && FIFO_NOT_EMPTY_FLAG)
    else $error("full without half");
  a_half_data: assert property (FIFO_HALF_FLAG |-> FIFO_NOT_EMPTY_FLAG)
    else $error("half while empty");
  a_fifo_clear: assert property (FIFO_DISABLE_BIT [*3] |-> !FIFO_NOT_EMPTY_FLAG)
    else $error("fifo not cleared");
  a_eoc_irq: assert property (IRQ1 && !IRQ_SOURCE_SELECT |-> FIFO_NOT_EMPTY_FLAG)
    else $error("eoc irq no data");
  a_half_irq: assert property ((IRQ_SOURCE_SELECT && FIFO_HALF_FLAG) [*2] |-> IRQ1)
    else $error("half irq missing");
  a_stop_hold: assert property (PRETRIGGER_MODE && $fell(|STOP_COUNT) |-> ##2 !CONV_START [*8])
    else $error("start after stop");
  c_full: cover property (FIFO_FULL_FLAG);
  c_half_irq: cover property (IRQ_SOURCE_SELECT && IRQ1);
  c_stop: cover property (PRETRIGGER_MODE && $fell(|STOP_COUNT));
endmodule
bind atf_ctrl atf_ctrl_checker i_atf_ctrl_checker (.MCLK, .RST_N, .IRQ_SOURCE_SELECT,
  .FIFO_DISABLE_BIT, .PRETRIGGER_MODE, .STOP_COUNT, .CONV_START, .FIFO_NOT_EMPTY_FLAG,
  .FIFO_HALF_FLAG, .FIFO_FULL_FLAG, .CONVERTER_IDLE_FLAG, .IRQ1);

// ===== tb/atf_conv_model.sv
// Converter model.
// Assumes start is a one-cycle pulse.
`timescale 1ns/1ps
module atf_conv_model #(
  parameter int LAT = 5
) (
  input wire logic clk,
  input wire logic start,
  input wire logic [15:0] val,
  input wire logic mute,
  output logic done,
  output logic [15:0] data
);
  // Answer after LAT cycles; data inverted outside the done cycle
  initial
  begin
    done = 0;
    data = 16'hA5A5;
    forever
    begin
      @(posedge clk);
      if (start && !mute)
      begin
        repeat (LAT) @(posedge clk);
        done <= 1;
        data <= val;
        @(posedge clk);
        done <= 0;
        data <= ~val;
      end
    end
  end
endmodule

// ===== tb/tb.sv
// Bench for atf_ctrl.
// Assumes the converter model above.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected %0t: got %h want %h", $time, a, b); end end
module tb;
  import atf_pkg::*;
  logic mclk, rst_n, tsel, xen, isel, fdis, swt, xin, pmode, pin, sld, rd, fast, mute;
  logic cst, cdone, ne, hf, ff, idle, irq;
  logic [DATA_W-1:0] val, cdat, fd, b;
  logic [STOP_W-1:0] sc, scv;
  logic [STOP_W-1:0] stops [2] = '{16'h0001, 16'h0003};
  logic [31:0] rows [5] = '{32'h7FFF_7FFF, 32'h8000_8000, 32'h0001_0001,
    32'hFFFF_FFFF, 32'hC000_C000};
  int mismatches, n_checks, i, k, n;
  atf_ctrl i_atf_ctrl (.MCLK(mclk), .RST_N(rst_n), .CE(1'b1), .TRIGGER_SOURCE_SELECT(tsel),
    .EXTERNAL_TRIGGER_ENABLE(xen), .IRQ_SOURCE_SELECT(isel), .FIFO_DISABLE_BIT(fdis),
    .FAST_VARIANT(fast), .SW_TRIGGER_WR(swt), .PACER_DIV1(16'h0004), .PACER_DIV2(16'h0004),
    .EXTERNAL_TRIGGER_INPUT(xin), .PRETRIGGER_MODE(pmode), .PRETRIGGER_INPUT(pin),
    .STOP_COUNT_LOAD(sld), .STOP_COUNT_VALUE(scv), .STOP_COUNT(sc), .CONV_START(cst),
    .CONV_DONE(cdone), .CONV_DATA(cdat), .FIFO_READ(rd), .FIFO_DATA(fd),
    .FIFO_NOT_EMPTY_FLAG(ne), .FIFO_HALF_FLAG(hf), .FIFO_FULL_FLAG(ff),
    .CONVERTER_IDLE_FLAG(idle), .IRQ1(irq));
  atf_conv_model i_atf_conv_model (.clk(mclk), .start(cst), .val(val), .done(cdone),
    .data(cdat), .mute(mute));
  task automatic tick(int m);
    repeat (m) @(posedge mclk);
  endtask
  task automatic sw();
    swt <= 1;
    tick(1);
    swt <= 0;
  endtask
  // Bounded wait for a flag
  task automatic wt(ref logic s);
    for (k = 0; k < 3000 && s !== 1'b1; k++)
      tick(1);
    `CHK(s, 1'b1)
  endtask
  // Check head word, then pop it
  task automatic rdw(logic [DATA_W-1:0] e);
    tick(2);
    `CHK(fd, e)
    rd <= 1;
    tick(1);
    rd <= 0;
    tick(2);
  endtask
  // Run, stepping the next word on each finished conversion
  task automatic run(ref logic s, input int m);
    for (k = 0; k < m && s !== 1'b1; k++)
    begin
      tick(1);
      if (cdone)
        val <= val + 1;
    end
  endtask
  task automatic cnt(int m);
    n = 0;
    repeat (m)
    begin
      tick(1);
      n += cst;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // Watchdog at about two and a half times the run
  initial
  begin
    #800000;
    mismatches++;
    give_verdict();
  end
  // Reset, table rows, then hand-written cases
  initial
  begin
    {tsel, xen, isel, fdis, swt, pmode, pin, sld, rd, val, fast, mute, scv} = '0;
    xin = 1;
    rst_n = 0;
    tick(20);
    rst_n <= 1;
    tick(2);
    `CHK({idle, ne, cst, irq}, 4'b1000)
    $display("reset done");
    foreach (rows[j])
    begin
      val <= rows[j][31:16];
      sw();
      tick(2);
      `CHK(idle, 1'b0)
      wt(ne);
      `CHK(irq, 1'b1)
      rdw(rows[j][15:0]);
      $display("row %0d done", j);
    end
    sw();
    tick(2);
    sw();
    wt(ne);
    rdw(val);
    tick(30);
    `CHK(ne, 1'b0)
    $display("retrigger done");
    xen <= 1;
    tsel <= 1;
    tick(60);
    `CHK(ne, 1'b0)
    xin <= 0;
    wt(ne);
    rdw(val);
    tick(30);
    `CHK(ne, 1'b0)
    {xen, xin} <= 2'b01;
    $display("external done");
    isel <= 1;
    tsel <= 1;
    b = val;
    run(hf, 30000);
    `CHK(16'(val - b), 16'h0200)
    tick(2);
    `CHK(irq, 1'b1)
    run(ff, 30000);
    `CHK(16'(val - b), 16'h0400)
    run(rd, 200);
    tsel <= 0;
    tick(20);
    for (i = 0; i < 1024; i++)
      rdw(16'(b + i));
    `CHK(ne, 1'b0)
    $display("pacer done");
    // Silent converter on the fast variant: the sequencer times out on its own
    fast <= 1;
    mute <= 1;
    sw();
    tick(1);
    for (n = 0; n < 2000 && idle !== 1'b1; n++)
      tick(1);
    `CHK(n, CONV_FAST_CYC + 1)
    {fast, mute} <= 2'b00;
    $display("timeout done");
    foreach (stops[j])
    begin
      {pmode, pin} <= 2'b00;
      scv <= stops[j];
      sld <= 1;
      tick(1);
      sld <= 0;
      tick(2);
      `CHK(sc, stops[j])
      pmode <= 1;
      tsel <= 1;
      cnt(100);
      `CHK(n > 2, 1'b1)
      wt(cst);
      pin <= 1;
      cnt(300);
      `CHK(n, stops[j])
      `CHK(sc, 16'h0000)
    end
    // Reset in mid-run clears the FIFO and its flags
    rst_n <= 0;
    tick(2);
    rst_n <= 1;
    tick(2);
    `CHK({ne, hf, ff, irq}, 4'b0000)
    tick(100);
    `CHK(ne, 1'b1)
    fdis <= 1;
    tick(3);
    fdis <= 0;
    tick(2);
    `CHK(ne, 1'b0)
    {pmode, pin, tsel} <= 3'b000;
    $display("pretrigger done");
    give_verdict();
  end
endmodule
